// File: dbc_pkg.sv
// Package of constants and types for the debug control block
package dbc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_DEBUG_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CORE_STATUS   = 4'h1;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         BIT_HALT         = 7;
  localparam int         BIT_BRK_EN       = 6;
  localparam int         BIT_ACK          = 5;
  localparam int         BIT_RESET        = 0;
  localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
  localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         RESET_PULSE_CYCLES = 4;
  localparam logic [2:0] RESET_PULSE_LAST   = 3'h3;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dbc_req_type;

  // Core-facing status
  typedef struct packed {
    logic halt;
    logic core_reset;
  } dbc_core_type;

endpackage : dbc_pkg

// File: dbc_sync.sv
// Two flip-flop synchroniser for one level
module dbc_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic sync_q;

  // First stage is read only by the second stage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : dbc_sync

// File: dbc_debug_control.sv
// Debug control register that halts, resumes and resets a core
//
// The register offsets and the plain strobed port were left to the implementer.
module dbc_debug_control (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Register port
  input  wire dbc_pkg::dbc_req_type req,
  output logic [7:0]                rdata,
  // Core side
  input  wire logic                 opcode_valid,
  input  wire logic [7:0]           opcode,
  output logic                      fetch_stall,
  output logic                      core_reset,
  output logic                      breakpoint_hit,
  // Option pin
  input  wire logic                 read_protect_pin
);

  // ----------------------------------------------------------------------
  // Read-protect option, a static pin, synchronised
  // ----------------------------------------------------------------------
  logic read_protect;

  dbc_sync u_rp_sync (
    .mclk (mclk),
    .rstn (rstn),
    .din  (read_protect_pin),
    .dout (read_protect)
  );

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  logic       halt_q,      halt_d;
  logic       brk_en_q,    brk_en_d;
  logic       ack_q,       ack_d;
  logic       rst_bit_q,   rst_bit_d;
  logic [2:0] rst_cnt_q,   rst_cnt_d;
  logic       core_rst_q,  core_rst_d;
  logic       halt_hold_q, halt_hold_d;
  logic       bp_q,        bp_d;
  logic [7:0] rdata_q,     rdata_d;

  logic ctrl_wr;
  logic brk_hit;

  assign ctrl_wr = req.wr && (req.addr == dbc_pkg::ADDR_DEBUG_CONTROL);
  // Breakpoint only counts while the core is fetching
  assign brk_hit = opcode_valid && !halt_q && !core_rst_q &&
                   (opcode == dbc_pkg::BREAKPOINT_OPCODE);

  // Next-state logic for the control register and reset sequencer
  always_comb begin
    halt_d      = halt_q;
    brk_en_d    = brk_en_q;
    ack_d       = ack_q;
    rst_bit_d   = rst_bit_q;
    rst_cnt_d   = rst_cnt_q;
    core_rst_d  = core_rst_q;
    halt_hold_d = halt_hold_q;
    bp_d        = 1'b0;
    if (ctrl_wr) begin
      brk_en_d = req.wdata[dbc_pkg::BIT_BRK_EN];
      ack_d    = req.wdata[dbc_pkg::BIT_ACK];
      if (req.wdata[dbc_pkg::BIT_HALT]) begin
        halt_d = 1'b1;
      end else if (!read_protect) begin
        halt_d = 1'b0;
      end
      if (req.wdata[dbc_pkg::BIT_RESET]) begin
        // Halt bit of the same write survives the reset: 81H vs 41H
        rst_bit_d   = 1'b1;
        core_rst_d  = 1'b1;
        rst_cnt_d   = 3'h0;
        halt_hold_d = req.wdata[dbc_pkg::BIT_HALT];
      end
    end
    // Breakpoint set wins over a software clear in the same cycle
    if (brk_hit && brk_en_q) begin
      halt_d = 1'b1;
      bp_d   = 1'b1;
    end
    if (core_rst_q) begin
      if (rst_cnt_q == dbc_pkg::RESET_PULSE_LAST) begin
        core_rst_d = 1'b0;
        rst_bit_d  = 1'b0;
        // Device reset clears the register, except the requested halt
        halt_d   = halt_hold_q;
        brk_en_d = 1'b0;
        ack_d    = 1'b0;
      end else begin
        rst_cnt_d = rst_cnt_q + 3'h1;
      end
    end
  end

  // Registers of the control state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      halt_q      <= dbc_pkg::CTRL_RESET_VALUE[dbc_pkg::BIT_HALT];
      brk_en_q    <= dbc_pkg::CTRL_RESET_VALUE[dbc_pkg::BIT_BRK_EN];
      ack_q       <= dbc_pkg::CTRL_RESET_VALUE[dbc_pkg::BIT_ACK];
      rst_bit_q   <= dbc_pkg::CTRL_RESET_VALUE[dbc_pkg::BIT_RESET];
      rst_cnt_q   <= 3'h0;
      core_rst_q  <= 1'b0;
      halt_hold_q <= 1'b0;
      bp_q        <= 1'b0;
    end else begin
      halt_q      <= halt_d;
      brk_en_q    <= brk_en_d;
      ack_q       <= ack_d;
      rst_bit_q   <= rst_bit_d;
      rst_cnt_q   <= rst_cnt_d;
      core_rst_q  <= core_rst_d;
      halt_hold_q <= halt_hold_d;
      bp_q        <= bp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read path, data valid the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        dbc_pkg::ADDR_DEBUG_CONTROL: begin
          rdata_d = {halt_q, brk_en_q, ack_q, 4'h0, rst_bit_q};
        end
        dbc_pkg::ADDR_CORE_STATUS: begin
          rdata_d = {5'h00, read_protect, core_rst_q, halt_q};
        end
        default: begin
          rdata_d = 8'h00;                    // Unmapped reads as zero
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata          = rdata_q;
  assign fetch_stall    = halt_q;
  assign core_reset     = core_rst_q;
  assign breakpoint_hit = bp_q;

endmodule : dbc_debug_control

// File: dbc_chk.sv
// Checker of the debug control block ports
module dbc_chk (
  // Clock and reset
  input wire logic                 mclk, rstn,
  // Register port
  input wire dbc_pkg::dbc_req_type req,
  input wire logic [7:0]           rdata, opcode,
  // Core side and option pin
  input wire logic   opcode_valid, fetch_stall, core_reset, breakpoint_hit,
  input wire logic   read_protect_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Write to the control register
  wire w0 = req.wr && req.addr == 4'h0;
  chk_stop_halt: assert property (
    w0 && req.wdata == 8'h81 |=> core_reset[*4] ##1 fetch_stall)
    else $error("stop write did not halt");
  chk_reset_go: assert property (
    w0 && req.wdata == 8'h41 |=> core_reset[*4] ##1 !fetch_stall)
    else $error("go write left core halted");
  chk_run_resume: assert property (
    w0 && req.wdata == 8'h40 && fetch_stall && !read_protect_pin && !core_reset
    && !$past(read_protect_pin, 3) |=> !fetch_stall && !core_reset)
    else $error("run write did not resume");
  chk_protect_hold: assert property (
    w0 && !req.wdata[7] && !req.wdata[0] && fetch_stall
    && read_protect_pin && $past(read_protect_pin, 3) |=> fetch_stall)
    else $error("protected halt was cleared");
  chk_brk_halt: assert property (
    breakpoint_hit |-> fetch_stall
    && $past(opcode_valid && opcode == dbc_pkg::BREAKPOINT_OPCODE))
    else $error("breakpoint hit without cause");
  chk_hit_single: assert property (
    breakpoint_hit |-> !$past(fetch_stall) ##1 !breakpoint_hit)
    else $error("breakpoint hit malformed");
  chk_pulse_len: assert property (
    $rose(core_reset) |-> core_reset[*4] ##1 !core_reset)
    else $error("reset pulse length wrong");
  chk_read_halt: assert property (
    req.rd && req.addr == 4'h0 |=> rdata[7] == $past(fetch_stall)
    && rdata[4:1] == 4'h0)
    else $error("control read wrong");
  chk_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  // Main scenarios
  cov_brk: cover property (breakpoint_hit);
  cov_stop: cover property (w0 && req.wdata == 8'h81);
  cov_prot: cover property (w0 && fetch_stall && read_protect_pin);
endmodule : dbc_chk

// File: dbc_core_model.sv
// Processor core model that fetches only while allowed
module dbc_core_model (
  input wire logic  mclk, rstn, fetch_stall, core_reset, brk_req,
  output logic       opcode_valid,
  output logic [7:0] opcode,
  output int         fetches
);
  timeunit 1ns;
  timeprecision 1ns;
  // No fetch in debug state or in reset; opcode changes when idle
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      opcode_valid <= 1'b0;
      fetches <= 0;
    end else begin
      opcode_valid <= !fetch_stall && !core_reset;
      opcode <= brk_req ? 8'h00 : 8'h01 | 8'(fetches);
      if (opcode_valid) fetches <= fetches + 1;
    end
  end
endmodule : dbc_core_model

// File: tb.sv
// Self-checking bench for the debug control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rstn = 0, brk_req = 0, rp = 0, ov, fs, cr, bh;
  int n_hit = 0;
  dbc_pkg::dbc_req_type req = '0;
  logic [7:0] rdata, op, w;
  int n_mismatch = 0, checks_done = 0, seed = 89862, f, f0;
  initial forever #25 mclk = ~mclk;
  dbc_debug_control uut (.mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata),
    .opcode_valid(ov), .opcode(op), .fetch_stall(fs), .core_reset(cr),
    .breakpoint_hit(bh), .read_protect_pin(rp));
  // Count breakpoint pulses so a stuck or missing pulse shows up
  always @(posedge mclk) if (bh === 1'b1) n_hit++;
  dbc_core_model core (.mclk(mclk), .rstn(rstn), .fetch_stall(fs),
    .core_reset(cr), .brk_req(brk_req), .opcode_valid(ov), .opcode(op),
    .fetches(f));
  function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
    return d & 8'hE0;
  endfunction : exp_ctrl
  task automatic chk(input string s, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) req.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [7:0] e, string s);
    @(posedge mclk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) req.rd <= 1'b0;
    #1 chk(s, rdata, e);
  endtask : rc
  task automatic bp;
    @(posedge mclk) brk_req <= 1'b1;
    @(posedge mclk) brk_req <= 1'b0;
    cyc(4);
  endtask : bp
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Sequence of scenarios, then the verdict
  initial begin
    cyc(6);
    rstn <= 1'b1;
    rc(4'h0, 8'h00, "ctrl reset");
    rc(4'h7, 8'h00, "unmapped");
    wr(4'h0, 8'h81);
    #1 chk("pulse", cr, 1'b1);
    cyc(6);
    rc(4'h0, 8'h80, "stop");
    f0 = f;
    cyc(8);
    chk("fetch held", 8'(f - f0), 8'h00);
    wr(4'h0, 8'h40);
    rc(4'h0, 8'h40, "run");
    f0 = f;
    cyc(4);
    chk("fetch run", {7'h0, f > f0}, 8'h01);
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h41);
    cyc(6);
    rc(4'h0, 8'h00, "go");
    bp;
    chk("brk off", fs, 1'b0);
    chk("hit none", 8'(n_hit), 8'h00);
    wr(4'h0, 8'h40);
    bp;
    rc(4'h0, 8'hC0, "brk on");
    chk("hit once", 8'(n_hit), 8'h01);
    @(posedge mclk) rp <= 1'b1;
    cyc(4);
    wr(4'h0, 8'h40);
    cyc(2);
    chk("protect", fs, 1'b1);
    rc(4'h1, 8'h05, "status");
    wr(4'h0, 8'h41);
    cyc(6);
    rc(4'h0, 8'h00, "protect reset");
    @(posedge mclk) rp <= 1'b0;
    cyc(4);
    repeat (24) begin
      w = 8'($random(seed)) & 8'hFE;
      wr(4'h0, w);
      rc(4'h0, exp_ctrl(w), "random");
      chk("stall", fs, w[7]);
    end
    final_report;
  end
  // Watchdog
  initial begin
    #60000;
    n_mismatch++;
    final_report;
  end
endmodule : tb
bind dbc_debug_control dbc_chk chk (.mclk(mclk), .rstn(rstn), .req(req),
  .rdata(rdata), .opcode(opcode), .opcode_valid(opcode_valid),
  .fetch_stall(fetch_stall), .core_reset(core_reset),
  .breakpoint_hit(breakpoint_hit), .read_protect_pin(read_protect_pin));
